/* File: shared/sec_err_pkg.sv */
package sec_err_pkg;

    // Register offsets in extended configuration space (byte addresses)
    localparam logic [11:0] OFF_SEVERITY = 12'h134;
    localparam logic [11:0] OFF_FIRST_PTR = 12'h138;
    localparam logic [11:0] OFF_LOG_W0 = 12'h13c;
    localparam logic [11:0] OFF_LOG_W1 = 12'h140;
    localparam logic [11:0] OFF_LOG_W2 = 12'h144;
    localparam logic [11:0] OFF_LOG_W3 = 12'h148;

    // Number of error classes, one per status bit position 13..0
    localparam int NUM_CLASSES = 14;

    // Severity register layout and reset
    localparam logic [13:0] SEV_RESET = 14'h1340;
    localparam logic [13:0] SEV_WRITABLE = 14'h3fee;
    localparam logic [13:0] SEV_FUNCTIONAL = 14'h1e8c;

    // Severity bit positions of each class
    localparam int INTERNAL_FAULT_LEVEL = 13;
    localparam int SYSTEM_ERR_SEEN_LEVEL = 12;
    localparam int PARITY_ERR_SEEN_LEVEL = 11;
    localparam int DELAYED_TXN_EXPIRY_LEVEL = 10;
    localparam int BAD_ADDRESS_LEVEL = 9;
    localparam int ATTRIBUTE_FAULT_LEVEL = 8;
    localparam int BAD_PAYLOAD_LEVEL = 7;
    localparam int SPLIT_MSG_PAYLOAD_LEVEL = 6;
    localparam int UNEXPECTED_SPLIT_LEVEL = 5;
    localparam int INITIATOR_ABORT_LEVEL = 3;
    localparam int RESPONDER_ABORT_LEVEL = 2;
    localparam int SPLIT_INITIATOR_ABORT_LEVEL = 1;

    // First error pointer field
    localparam int PTR_WIDTH = 5;
    localparam logic [4:0] PTR_RESET = 5'h00;

    // Failing cycle log layout
    localparam int LOG_WIDTH = 128;
    localparam int LOG_CMD_FIRST_LSB = 36;
    localparam int LOG_CMD_SECOND_LSB = 40;
    localparam int LOG_ADDR_FIRST_LSB = 64;
    localparam int LOG_ADDR_SECOND_LSB = 96;
    localparam logic [127:0] LOG_RESET = 128'h0;

    // Secondary PCI cycle that caused an error
    typedef struct packed {
        logic [31:0] addrFirst;
        logic [31:0] addrSecond;
        logic [3:0] cmdFirst;
        logic [3:0] cmdSecond;
        logic dualAddr;
    } cycle_info_t;

    // Upstream error message request
    typedef struct packed {
        logic valid;
        logic fatal;
    } err_msg_t;

    // Configuration access request
    typedef struct packed {
        logic [11:0] addr;
        logic [3:0] byteEn;
        logic [31:0] wrData;
        logic wrEn;
        logic rdEn;
    } cfg_req_t;

endpackage

/* File: src/sec_err_log_capture.sv */
`timescale 1ns/1ps
`default_nettype none

module sec_err_log_capture (
    // Clock and resets
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic syncClear,
    // Capture request
    input wire logic capture,
    input wire sec_err_pkg::cycle_info_t cycleInfo,
    // Log contents
    output logic [127:0] logData
);

    logic [127:0] log_ff;
    logic [127:0] nxt_log;
    logic [31:0] upperAddr;

    // Single-address cycles leave the upper address word at zero
    assign upperAddr = cycleInfo.dualAddr ? cycleInfo.addrSecond : 32'h0;

    // Attribute and reserved spans stay zero by construction
    always_comb begin
        nxt_log = 128'h0;
        nxt_log[sec_err_pkg::LOG_ADDR_FIRST_LSB +: 32] = cycleInfo.addrFirst;
        nxt_log[sec_err_pkg::LOG_ADDR_SECOND_LSB +: 32] = upperAddr;
        nxt_log[sec_err_pkg::LOG_CMD_FIRST_LSB +: 4] = cycleInfo.cmdFirst;
        if (cycleInfo.dualAddr) begin
            nxt_log[sec_err_pkg::LOG_CMD_SECOND_LSB +: 4] = cycleInfo.cmdSecond;
        end
    end

    // Newest error overwrites the log
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            log_ff <= sec_err_pkg::LOG_RESET;
        end else if (syncClear) begin
            log_ff <= sec_err_pkg::LOG_RESET;
        end else if (capture) begin
            log_ff <= nxt_log;
        end
    end

    assign logData = log_ff;

endmodule // sec_err_log_capture

`default_nettype wire

/* File: src/secondary_error_severity_log.sv */
// How it works
// - Severity register at 0x134, set means fatal
// - Severity resets to 0x00001340
// - Unmasked error, severity one: fatal message
// - Unmasked error, severity zero: nonfatal message
// - Bit 10 classifies discard timer expiry
// - PCI-X severity bits are plain storage
// - Severity reserved bits read zero
// - Three resets restore all marked fields
// - Read-only first error pointer at 0x138
// - Pointer bits 31:5 read zero
// - Log captures cycle of latest error
// - Log read as four words 0x13c-0x148
// - Address phases in bits 95:64, 127:96
// - Single address cycle zeroes bits 127:96
// - First phase command in bits 39:36
// - Second phase command in bits 43:40
// - Log bits 35:0 read zero
// - Log bits 63:44 read zero
// - Masked errors cause no effect
`timescale 1ns/1ps
`default_nettype none

module secondary_error_severity_log (
    // Clock and power-on reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Other reset sources, synchronous, active low
    input wire logic pcieResetN,
    input wire logic global_reset_inputN,
    // Configuration access
    input wire sec_err_pkg::cfg_req_t cfgReq,
    output logic cfgHit,
    output logic cfgRdValid,
    output logic [31:0] cfgRdData,
    // Secondary PCI error sources
    input wire logic [13:0] errEvent,
    input wire sec_err_pkg::cycle_info_t errCycle,
    // Mask and status registers held elsewhere
    input wire logic [13:0] errMask,
    input wire logic statusPending,
    // Results
    output logic [13:0] statusSet,
    output sec_err_pkg::err_msg_t errMsg,
    output logic [13:0] severity,
    output logic [4:0] earliest_fault_index
);

    // Highest pending class wins when several fire together
    function automatic logic [4:0] pick_class(input logic [13:0] vec);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = 0; i < sec_err_pkg::NUM_CLASSES; i++) begin
            if (vec[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction

    // Byte-enable merge used for every writable word
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] oldVal,
        input logic [31:0] newVal,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = oldVal;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = newVal[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Compare an access address with a register offset
    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
        return a[11:2] == off[11:2];
    endfunction

    //------------------------------------------------------------
    // Reset combining
    //------------------------------------------------------------

    // Fundamental and global resets act as synchronous clears
    logic syncClear;
    assign syncClear = !pcieResetN || !global_reset_inputN;

    //------------------------------------------------------------
    // Address decode
    //------------------------------------------------------------

    logic hitSev;
    logic hitPtr;
    logic hitLog0;
    logic hitLog1;
    logic hitLog2;
    logic hitLog3;
    logic hitAny;
    logic sevWrite;

    // One aligned word per register
    assign hitSev = addr_is(cfgReq.addr, sec_err_pkg::OFF_SEVERITY);
    assign hitPtr = addr_is(cfgReq.addr, sec_err_pkg::OFF_FIRST_PTR);
    assign hitLog0 = addr_is(cfgReq.addr, sec_err_pkg::OFF_LOG_W0);
    assign hitLog1 = addr_is(cfgReq.addr, sec_err_pkg::OFF_LOG_W1);
    assign hitLog2 = addr_is(cfgReq.addr, sec_err_pkg::OFF_LOG_W2);
    assign hitLog3 = addr_is(cfgReq.addr, sec_err_pkg::OFF_LOG_W3);
    assign hitAny = hitSev | hitPtr | hitLog0 | hitLog1 | hitLog2 | hitLog3;
    assign cfgHit = hitAny;

    // Writes to pointer and log words are dropped: they are read-only
    assign sevWrite = cfgReq.wrEn && hitSev;

    //------------------------------------------------------------
    // Severity register
    //------------------------------------------------------------

    logic [13:0] sev_ff;
    logic [31:0] sevMerged;
    logic [13:0] nxt_sev;

    // Reserved positions are never stored, so they always read zero
    assign sevMerged = merge_bytes({18'h0, sev_ff}, cfgReq.wrData, cfgReq.byteEn);
    assign nxt_sev = sevMerged[13:0] & sec_err_pkg::SEV_WRITABLE;

    // PCI-X bits are held here like the rest but steer nothing
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sev_ff <= sec_err_pkg::SEV_RESET;
        end else if (syncClear) begin
            sev_ff <= sec_err_pkg::SEV_RESET;
        end else if (sevWrite) begin
            sev_ff <= nxt_sev;
        end
    end

    assign severity = sev_ff;

    //------------------------------------------------------------
    // Error qualification
    //------------------------------------------------------------

    logic [13:0] liveErr;
    logic [13:0] fatalErr;
    logic anyErr;
    logic anyFatal;

    // PCI-X classes never fire here, and masked classes are dropped
    assign liveErr = errEvent & ~errMask & sec_err_pkg::SEV_FUNCTIONAL;

    // Severity is sampled in the same cycle the event is seen
    assign fatalErr = liveErr & sev_ff;
    assign anyErr = |liveErr;
    assign anyFatal = |fatalErr;

    //------------------------------------------------------------
    // Status set pulses and upstream message
    //------------------------------------------------------------

    logic [13:0] statusSet_ff;
    sec_err_pkg::err_msg_t msg_ff;
    sec_err_pkg::err_msg_t nxt_msg;

    // A fatal class in the batch makes the whole message fatal
    assign nxt_msg = '{valid: anyErr, fatal: anyErr && anyFatal};

    // Status pulse and message leave on the same edge as the log load
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            statusSet_ff <= 14'h0;
            msg_ff <= '0;
        end else if (syncClear) begin
            statusSet_ff <= 14'h0;
            msg_ff <= '0;
        end else begin
            statusSet_ff <= liveErr;
            msg_ff <= nxt_msg;
        end
    end

    assign statusSet = statusSet_ff;
    assign errMsg = msg_ff;

    //------------------------------------------------------------
    // First error pointer
    //------------------------------------------------------------

    logic [4:0] ptr_ff;
    logic ptrLoad;

    // Only the first error after the status register empties is kept;
    // later ones are dropped while the pending status stays set
    assign ptrLoad = anyErr && !statusPending;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ptr_ff <= sec_err_pkg::PTR_RESET;
        end else if (syncClear) begin
            ptr_ff <= sec_err_pkg::PTR_RESET;
        end else if (ptrLoad) begin
            ptr_ff <= pick_class(liveErr);
        end
    end

    assign earliest_fault_index = ptr_ff;

    //------------------------------------------------------------
    // Failing cycle log
    //------------------------------------------------------------

    logic [127:0] logData;

    // Masked errors never reach the capture strobe
    sec_err_log_capture logUnit (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .syncClear(syncClear),
        .capture(anyErr),
        .cycleInfo(errCycle),
        .logData(logData)
    );

    //------------------------------------------------------------
    // Read path
    //------------------------------------------------------------

    logic [31:0] rdMux;
    logic [31:0] rdData_ff;
    logic rdValid_ff;

    // Unmapped offsets answer zero so the bus never stalls
    assign rdMux = hitSev ? {18'h0, sev_ff} :
                   hitPtr ? {27'h0, ptr_ff} :
                   hitLog0 ? logData[31:0] :
                   hitLog1 ? logData[63:32] :
                   hitLog2 ? logData[95:64] :
                   hitLog3 ? logData[127:96] :
                   32'h0;

    // Read data is registered; valid follows the strobe by one cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdData_ff <= 32'h0;
            rdValid_ff <= 1'b0;
        end else begin
            rdValid_ff <= cfgReq.rdEn;
            if (cfgReq.rdEn) begin
                rdData_ff <= rdMux;
            end
        end
    end

    assign cfgRdData = rdData_ff;
    assign cfgRdValid = rdValid_ff;

endmodule // secondary_error_severity_log

`default_nettype wire

/* File: tb/pci_err_source.sv */
`timescale 1ns/1ps
`default_nettype none

module pci_err_source (
    // Request from the bench
    input wire logic [13:0] fireClass,
    input wire logic dual,
    input wire logic [7:0] tag,
    // Toward the bridge
    output logic [13:0] errEvent,
    output sec_err_pkg::cycle_info_t errCycle
);
    // Fields follow the tag so each cycle is recognisable; second-phase fields
    // carry junk even on single cycles, so the log has to clear them itself
    assign errEvent = fireClass;
    assign errCycle = '{addrFirst: {4{tag}}, addrSecond: ~{4{tag}}, cmdFirst: tag[3:0],
        cmdSecond: tag[7:4], dualAddr: dual};
endmodule // pci_err_source

`default_nettype wire

/* File: tb/sec_err_severity_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module sec_err_severity_chk (
    // Clock and resets
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic pcieResetN,
    input wire logic global_reset_inputN,
    // Configuration access
    input wire sec_err_pkg::cfg_req_t cfgReq,
    input wire logic cfgHit,
    input wire logic cfgRdValid,
    input wire logic [31:0] cfgRdData,
    // Error side
    input wire logic [13:0] errEvent,
    input wire sec_err_pkg::cycle_info_t errCycle,
    input wire logic [13:0] errMask,
    input wire logic statusPending,
    input wire logic [13:0] statusSet,
    input wire sec_err_pkg::err_msg_t errMsg,
    input wire logic [13:0] severity,
    input wire logic [4:0] earliest_fault_index
);
    // Unmasked events of working classes; PCI-X classes must never report
    wire logic live = pcieResetN & global_reset_inputN;
    wire logic [13:0] hit = errEvent & ~errMask & sec_err_pkg::SEV_FUNCTIONAL;
    wire logic fatalHit = |(hit & severity);
    logic [13:0] hitQ_ff;

    // Remember the batch so the pointer can be judged one cycle later
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
            hitQ_ff <= 14'h0;
        else
            hitQ_ff <= hit;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_read_answer:
        assert property (cfgReq.rdEn |=> cfgRdValid) else $error("read not answered");
    a_answer_cause:
        assert property (cfgRdValid |-> $past(cfgReq.rdEn)) else $error("answer without read");
    a_hit_decode:
        assert property (cfgHit == (cfgReq.addr[11:2] >= 10'h04d && cfgReq.addr[11:2] <= 10'h052))
        else $error("address decode wrong");
    a_sev_read:
        assert property (cfgReq.rdEn && cfgReq.addr[11:2] == 10'h04d
            |=> cfgRdData == {18'h0, $past(severity)}) else $error("severity read wrong");
    a_sev_reserved:
        assert property ((severity & ~sec_err_pkg::SEV_WRITABLE) == 14'h0)
        else $error("reserved severity bit set");
    a_sync_reset:
        assert property (!live |=> severity == sec_err_pkg::SEV_RESET
            && earliest_fault_index == 5'h0) else $error("sync reset not applied");
    a_report_batch:
        assert property (|hit && live |=> errMsg.valid && statusSet == $past(hit)
            && errMsg.fatal == $past(fatalHit)) else $error("error report wrong");
    a_masked_quiet:
        assert property (hit == 14'h0 |=> !errMsg.valid && statusSet == 14'h0)
        else $error("report without unmasked error");
    a_ptr_hold:
        assert property (statusPending && live |=> $stable(earliest_fault_index))
        else $error("pointer moved while status pending");
    a_ptr_class:
        assert property (|hit && !statusPending && live
            |=> (hitQ_ff >> earliest_fault_index) == 14'h1) else $error("pointer wrong");
endmodule // sec_err_severity_chk

bind secondary_error_severity_log sec_err_severity_chk sec_err_severity_chk_i (
    .clk_sys, .resetn, .pcieResetN, .global_reset_inputN, .cfgReq, .cfgHit, .cfgRdValid,
    .cfgRdData, .errEvent, .errCycle, .errMask, .statusPending, .statusSet, .errMsg,
    .severity, .earliest_fault_index
);

`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic pcieResetN = 1'b1;
    logic global_reset_inputN = 1'b1;
    sec_err_pkg::cfg_req_t cfgReq = '0;
    logic [13:0] errMask = 14'h0;
    logic statusPending = 1'b0;
    logic [13:0] fireClass = 14'h0;
    logic dual = 1'b0;
    logic [7:0] tag = 8'h0;
    logic cfgHit, cfgRdValid;
    logic [31:0] cfgRdData;
    logic [13:0] errEvent, statusSet, severity;
    sec_err_pkg::cycle_info_t errCycle;
    sec_err_pkg::err_msg_t errMsg;
    logic [4:0] earliest_fault_index;
    int errors = 0;
    int tests_run = 0;
    int cls[7] = '{12, 11, 10, 9, 7, 3, 2};

    // 50 MHz system clock
    always #10 clk_sys = ~clk_sys;

    pci_err_source pci_err_source_i (.fireClass, .dual, .tag, .errEvent, .errCycle);
    secondary_error_severity_log secondary_error_severity_log_i (.clk_sys, .resetn,
        .pcieResetN, .global_reset_inputN, .cfgReq, .cfgHit, .cfgRdValid, .cfgRdData,
        .errEvent, .errCycle, .errMask, .statusPending, .statusSet, .errMsg, .severity,
        .earliest_fault_index);

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        if (errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Inputs change on the falling edge, so the rising edge sees them settled
    task automatic cfg_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
        @(negedge clk_sys);
        cfgReq = '{addr: a, byteEn: be, wrData: d, wrEn: 1'b1, rdEn: 1'b0};
        @(negedge clk_sys);
        cfgReq = '0;
    endtask

    task automatic cfg_rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        @(negedge clk_sys);
        cfgReq = '{addr: a, byteEn: 4'hf, wrData: 32'h0, wrEn: 1'b0, rdEn: 1'b1};
        @(negedge clk_sys);
        cfgReq = '0;
        check("read valid", 32'h1, 32'(cfgRdValid));
        check(what, exp, cfgRdData);
    endtask

    task automatic fire(input int c, input logic dl, input logic [7:0] t,
            input logic [13:0] expSt, input logic [1:0] expMsg, input logic [4:0] expPtr);
        @(negedge clk_sys);
        fireClass = 14'h1 << c;
        dual = dl;
        tag = t;
        @(negedge clk_sys);
        fireClass = 14'h0;
        check("status set", 32'(expSt), 32'(statusSet));
        check("message", 32'(expMsg), 32'(errMsg));
        check("first error", 32'(expPtr), 32'(earliest_fault_index));
    endtask

    task automatic sync_reset(input logic viaLink);
        @(negedge clk_sys);
        pcieResetN = !viaLink;
        global_reset_inputN = viaLink;
        @(negedge clk_sys);
        pcieResetN = 1'b1;
        global_reset_inputN = 1'b1;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        test_done();
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys) resetn = 1'b1;
        // Reset contents, read-only words and an unmapped word
        cfg_rd(12'h134, 32'h00001340, "severity");
        for (int i = 0; i < 5; i++)
            cfg_rd(12'h138 + 12'(4 * i), 32'h0, "pointer or log");
        cfg_rd(12'h150, 32'h0, "unmapped");
        cfg_wr(12'h134, 32'hffffffff, 4'hf);
        cfg_rd(12'h134, 32'h00003fee, "severity all ones");
        cfg_wr(12'h138, 32'hffffffff, 4'hf);
        cfg_rd(12'h138, 32'h0, "pointer after write");
        cfg_wr(12'h134, 32'h0, 4'hf);
        cfg_rd(12'h134, 32'h0, "severity cleared");
        // A class that defaults to fatal reports nonfatal once its bit is cleared
        fire(12, 1'b0, 8'h44, 14'h1000, 2'b10, 5'd12);
        // Global reset restores defaults, then every working class reports at its level
        sync_reset(1'b0);
        cfg_rd(12'h134, 32'h00001340, "severity after reset");
        foreach (cls[i])
            fire(cls[i], 1'b0, 8'h5a, 14'h1 << cls[i],
                {1'b1, sec_err_pkg::SEV_RESET[cls[i]]}, 5'(cls[i]));
        cfg_rd(12'h13c, 32'h0, "log word0");
        cfg_rd(12'h140, 32'h000000a0, "log word1 single");
        cfg_rd(12'h144, 32'h5a5a5a5a, "log word2 single");
        cfg_rd(12'h148, 32'h0, "log word3 single");
        // One byte lane only, then a dual cycle while status is pending
        cfg_wr(12'h134, 32'hffffffff, 4'b0010);
        cfg_rd(12'h134, 32'h00003f40, "severity lane1");
        statusPending = 1'b1;
        fire(10, 1'b0, 8'h33, 14'h0400, 2'b11, 5'd2);
        fire(11, 1'b1, 8'hc3, 14'h0800, 2'b11, 5'd2);
        cfg_rd(12'h140, 32'h00000c30, "log word1 dual");
        cfg_rd(12'h144, 32'hc3c3c3c3, "log word2 dual");
        cfg_rd(12'h148, 32'h3c3c3c3c, "log word3 dual");
        // Masked class and PCI-X class leave everything alone
        statusPending = 1'b0;
        errMask = 14'h0800;
        fire(11, 1'b0, 8'h11, 14'h0, 2'b00, 5'd2);
        errMask = 14'h0;
        fire(8, 1'b0, 8'h22, 14'h0, 2'b00, 5'd2);
        cfg_rd(12'h144, 32'hc3c3c3c3, "log kept");
        // Link reset clears log and pointer too
        sync_reset(1'b1);
        cfg_rd(12'h134, 32'h00001340, "severity link reset");
        cfg_rd(12'h144, 32'h0, "log link reset");
        check("pointer link reset", 32'h0, 32'(earliest_fault_index));
        test_done();
    end
endmodule // tb_top

`default_nettype wire
